// >>> tbf_map.svh
/*
 * Constants for the tri-port two-queue FIFO block: widths, depth,
 * offset defaults, flag-select codes and offset word layout.
 * Assumes it is included by name from every file that needs it.
 */
`ifndef TBF_MAP_SVH
`define TBF_MAP_SVH

`define TBF_WIDE     36
`define TBF_HALF     18
`define TBF_DEPTH    32
`define TBF_CNTW     6
`define TBF_OFFW     7

// default thresholds picked by the flag-select pins at master reset
`define TBF_OFF_8    7'h08
`define TBF_OFF_16   7'h10
`define TBF_OFF_64   7'h40

// flag-select codes {flagSelect1, flagSelect0}
`define TBF_FS_PROG  2'h0
`define TBF_FS_8     2'h1
`define TBF_FS_16    2'h2
`define TBF_FS_64    2'h3

// offset word layout, used by the parallel and the serial load
`define TBF_AE1_LSB  0
`define TBF_AF1_LSB  8
`define TBF_AE2_LSB  16
`define TBF_AF2_LSB  24
`define TBF_SER_LAST 5'h1B

`endif

// >>> tbf_pkg.sv
/*
 * Types shared by the tri-port two-queue FIFO block.
 * Assumes tbf_map.svh is on the include path.
 */
package tbf_pkg;
	// almost-empty and almost-full thresholds of one queue
	typedef struct packed {
		logic [6:0] ae;
		logic [6:0] af;
	} tbf_offs_t;

	// settings latched at a queue's master reset
	typedef struct packed {
		logic bigEndian;
		logic progMode;
	} tbf_cfg_t;

	// state of the 36-to-18 output stage
	typedef enum logic [1:0] {OS_EMPTY, OS_FIRST, OS_SECOND} tbf_ostate_t;
endpackage

// >>> tbf_fifo.sv
/*
 * One dual-port queue: memory array, pointers and a word count, with
 * valid/ready on both sides and a synchronous flush.
 * Assumes a single clock; both sides may act in the same cycle.
 */
`timescale 1ns/1ps
`include "tbf_map.svh"
module tbf_fifo #(
	parameter int W = 36,
	parameter int D = 32
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   flush,
	input  wire logic [W-1:0]           inData,
	input  wire logic                   inValid,
	output logic                        inReady,
	output logic [W-1:0]                outData,
	output logic                        outValid,
	input  wire logic                   outReady,
	output logic [$clog2(D):0]          count
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULLN = (AW+1)'(D);

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic          push;
	logic          pop;

	// refusal of a write when full and a read when empty lives here
	assign inReady  = (count != FULLN);
	assign outValid = (count != '0);
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;
	assign outData  = mem[rdPtr];

	// storage carries no reset: contents are don't-care until written
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	// pointers move independently, so read and write may coincide
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else if (flush) begin
			wrPtr <= '0; // back to the first location
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) wrPtr <= wrPtr + 1'b1;
			if (pop) rdPtr <= rdPtr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	a_count_bound: assert property (@(posedge clk) disable iff (rst) count <= FULLN)
		else $error("queue count above depth");
	a_full_refuse: assert property (@(posedge clk) disable iff (rst)
		(!inReady && inValid && !outReady && !flush) |=> count == $past(count))
		else $error("write into full queue changed count");
	a_flush_clear: assert property (@(posedge clk) disable iff (rst) flush |=> !outValid && inReady)
		else $error("flush left data in queue");
endmodule

// >>> tbf_mailbox.sv
/*
 * One bypass mailbox: a word register and its new-mail flag.
 * Assumes writer and reader strobes are on the block clock.
 */
`timescale 1ns/1ps
module tbf_mailbox #(
	parameter int W = 18
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         clear,
	input  wire logic         wrEn,
	input  wire logic [W-1:0] wrData,
	input  wire logic         rdEn,
	output logic [W-1:0]      rdData,
	output logic              flag
);
	// the word skips the queue memory entirely
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdData <= '0;
		end else if (wrEn) begin
			rdData <= wrData;
		end
	end

	// new mail sets the flag; a write in the reading cycle wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag <= 1'b0;
		end else if (wrEn) begin
			flag <= 1'b1;
		end else if (rdEn || clear) begin
			flag <= 1'b0;
		end
	end

	a_mail_flag: assert property (@(posedge clk) disable iff (rst) wrEn |=> flag)
		else $error("mail flag not set by write");
	a_mail_data: assert property (@(posedge clk) disable iff (rst) wrEn |=> rdData == $past(wrData))
		else $error("mailbox lost written word");
endmodule

// >>> tbf_top.sv
/*
 * Tri-port two-queue FIFO: queue one carries 36-bit port A words to
 * 18-bit port B, queue two carries port C half-words to port A.
 * Assumes every port strobe is synchronous to clk; each port's
 * enables mark its own transfer edges.
 */
`timescale 1ns/1ps
`include "tbf_map.svh"
module tbf_top
	import tbf_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 fullResetQueueOne,
	input  wire logic                 fullResetQueueTwo,
	input  wire logic                 flushResetQueueOne,
	input  wire logic                 flushResetQueueTwo,
	input  wire logic                 flagSelect0,
	input  wire logic                 flagSelect1,
	input  wire logic                 bigEndianSel,
	input  wire logic                 serialOffsetIn,
	input  wire logic                 serialOffsetEn,
	input  wire logic                 outputModeSelect,
	input  wire logic [35:0]          portAIn,
	output logic      [35:0]          portAOut,
	output logic                      portAOe_n,
	input  wire logic                 portAOutEnable,
	input  wire logic                 portAWrite,
	input  wire logic                 portARead,
	input  wire logic                 portAMailSel,
	input  wire logic                 portAProgSel,
	output logic                      portAFullOrRoom,
	output logic                      portAEmptyOrValid,
	output logic                      portAAlmostEmpty,
	output logic                      portAAlmostFull,
	output logic                      mailFlagOne,
	output logic                      mailFlagTwo,
	output logic      [17:0]          portBOut,
	input  wire logic                 portBRead,
	input  wire logic                 portBMailSel,
	output logic                      portBEmptyOrValid,
	output logic                      portBAlmostEmpty,
	input  wire logic [17:0]          portCIn,
	input  wire logic                 portCWrite,
	input  wire logic                 portCMailSel,
	output logic                      portCFullOrRoom,
	output logic                      portCAlmostFull
);
	tbf_cfg_t            cfg1;
	tbf_cfg_t            cfg2;
	tbf_offs_t           offs1;
	tbf_offs_t           offs2;
	tbf_ostate_t         bState;
	logic [1:0]          flagSel;
	logic                fallThrough;
	logic                q1Clear;
	logic                q2Clear;
	logic [35:0]         q1Data;
	logic [35:0]         q2Data;
	logic [35:0]         q2InWord;
	logic                q1Valid;
	logic                q2Valid;
	logic                q1InReady;
	logic                q2InReady;
	logic                q1Pop;
	logic                q2Pop;
	logic                q1Take;
	logic                q2Take;
	logic                q1Push;
	logic                q2Push;
	logic [5:0]          q1Count;
	logic [5:0]          q2Count;
	logic [35:0]         bHold;
	logic                aShown;
	logic                cHalf;
	logic [17:0]         cLow;
	logic                aWr;
	logic                aRd;
	logic                bRd;
	logic                cWr;
	logic                parLoad;
	logic                serLoad;
	logic [26:0]         serReg;
	logic [4:0]          serBits;
	logic [27:0]         serWord;
	logic [17:0]         mb1Data;
	logic [17:0]         mb2Data;
	logic                showSecond;

	// default threshold for a flag-select code; programming mode starts at 8
	function automatic logic [6:0] defOff(input logic [1:0] fs);
		logic [6:0] v;
		v = `TBF_OFF_8;
		if (fs == `TBF_FS_16) begin
			v = `TBF_OFF_16;
		end else if (fs == `TBF_FS_64) begin
			v = `TBF_OFF_64;
		end
		return v;
	endfunction

	// port strobes, each valid only on its enable at a clk edge
	assign flagSel     = {flagSelect1, flagSelect0};
	assign fallThrough = outputModeSelect; // level read every cycle
	assign q1Clear     = fullResetQueueOne || flushResetQueueOne;
	assign q2Clear     = fullResetQueueTwo || flushResetQueueTwo;
	assign aWr         = portAWrite && !portAMailSel && !portAProgSel;
	assign aRd         = portARead && !portAMailSel;
	assign bRd         = portBRead && !portBMailSel;
	assign cWr         = portCWrite && !portCMailSel;
	assign parLoad     = portAWrite && portAProgSel && !portAMailSel;
	assign serWord     = {serReg, serialOffsetIn};
	assign serLoad     = serialOffsetEn && (serBits == `TBF_SER_LAST);

	// queue one: port A writes 36-bit words, port B drains halves
	assign q1Push = aWr;
	tbf_fifo #(.W(`TBF_WIDE), .D(`TBF_DEPTH)) uQueueOne (
		.clk      (clk),
		.rst      (rst),
		.flush    (q1Clear),
		.inData   (portAIn),
		.inValid  (q1Push),
		.inReady  (q1InReady),
		.outData  (q1Data),
		.outValid (q1Valid),
		.outReady (q1Pop),
		.count    (q1Count)
	);

	// queue two: port C pairs halves into a word, port A reads it
	assign q2InWord = cfg2.bigEndian ? {cLow, portCIn} : {portCIn, cLow};
	assign q2Push   = cWr && cHalf;
	tbf_fifo #(.W(`TBF_WIDE), .D(`TBF_DEPTH)) uQueueTwo (
		.clk      (clk),
		.rst      (rst),
		.flush    (q2Clear),
		.inData   (q2InWord),
		.inValid  (q2Push),
		.inReady  (q2InReady),
		.outData  (q2Data),
		.outValid (q2Valid),
		.outReady (q2Pop),
		.count    (q2Count)
	);

	// mailboxes: A to B and C to A, 18 bits like the narrow ports
	tbf_mailbox #(.W(`TBF_HALF)) uMailOne (
		.clk    (clk),
		.rst    (rst),
		.clear  (fullResetQueueOne),
		.wrEn   (portAWrite && portAMailSel),
		.wrData (portAIn[17:0]),
		.rdEn   (portBRead && portBMailSel),
		.rdData (mb1Data),
		.flag   (mailFlagOne)
	);
	tbf_mailbox #(.W(`TBF_HALF)) uMailTwo (
		.clk    (clk),
		.rst    (rst),
		.clear  (fullResetQueueTwo),
		.wrEn   (portCWrite && portCMailSel),
		.wrData (portCIn),
		.rdEn   (portARead && portAMailSel),
		.rdData (mb2Data),
		.flag   (mailFlagTwo)
	);

	// byte order and programming method latch only at master reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg1 <= '0;
			cfg2 <= '0;
		end else begin
			if (fullResetQueueOne) begin
				cfg1.bigEndian <= bigEndianSel;
				cfg1.progMode  <= (flagSel == `TBF_FS_PROG);
			end
			if (fullResetQueueTwo) begin
				cfg2.bigEndian <= bigEndianSel;
				cfg2.progMode  <= (flagSel == `TBF_FS_PROG);
			end
		end
	end

	// serial offset shifter, first bit lands in the top of the word
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			serReg  <= '0;
			serBits <= '0;
		end else if (fullResetQueueOne || fullResetQueueTwo) begin
			serBits <= '0;
		end else if (serialOffsetEn) begin
			serReg  <= serWord[26:0];
			serBits <= serLoad ? 5'h00 : serBits + 5'h01;
		end
	end

	// queue one offsets: defaults at master reset, kept by partial reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			offs1 <= {`TBF_OFF_8, `TBF_OFF_8};
		end else if (fullResetQueueOne) begin
			offs1 <= {defOff(flagSel), defOff(flagSel)};
		end else if (cfg1.progMode && parLoad) begin
			offs1 <= {portAIn[`TBF_AE1_LSB +: 7], portAIn[`TBF_AF1_LSB +: 7]};
		end else if (cfg1.progMode && serLoad) begin
			offs1 <= {serWord[`TBF_AE1_LSB +: 7], serWord[`TBF_AF1_LSB +: 7]};
		end
	end

	// queue two offsets, same scheme under its own reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			offs2 <= {`TBF_OFF_8, `TBF_OFF_8};
		end else if (fullResetQueueTwo) begin
			offs2 <= {defOff(flagSel), defOff(flagSel)};
		end else if (cfg2.progMode && parLoad) begin
			offs2 <= {portAIn[`TBF_AE2_LSB +: 7], portAIn[`TBF_AF2_LSB +: 7]};
		end else if (cfg2.progMode && serLoad) begin
			offs2 <= {serWord[`TBF_AE2_LSB +: 7], serWord[`TBF_AF2_LSB +: 7]};
		end
	end

	// port B pops: standard pops on request, fall-through refills itself
	assign q1Pop  = fallThrough ? (bState == OS_EMPTY || (bRd && bState == OS_SECOND))
	                            : (bRd && bState != OS_SECOND);
	assign q1Take = q1Pop && q1Valid && !q1Clear;
	assign showSecond = bRd && !q1Take && (fallThrough ? bState == OS_FIRST : bState == OS_SECOND);

	// port B output stage holds one word and hands out its halves
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bState <= OS_EMPTY;
			bHold  <= '0;
		end else if (q1Clear) begin
			bState <= OS_EMPTY;
		end else begin
			case (bState)
				OS_EMPTY: begin
					if (q1Take) begin
						bHold  <= q1Data;
						bState <= fallThrough ? OS_FIRST : OS_SECOND;
					end
				end
				OS_FIRST: begin
					if (bRd) bState <= OS_SECOND;
				end
				default: begin
					if (q1Take) begin
						bHold  <= q1Data;
						bState <= fallThrough ? OS_FIRST : OS_SECOND;
					end else if (bRd) begin
						bState <= OS_EMPTY;
					end
				end
			endcase
		end
	end

	// port B data register; endian picks which half goes first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			portBOut <= '0;
		end else if (q1Take) begin
			portBOut <= cfg1.bigEndian ? q1Data[35:18] : q1Data[17:0];
		end else if (showSecond) begin
			portBOut <= cfg1.bigEndian ? bHold[17:0] : bHold[35:18];
		end else if (portBRead && portBMailSel) begin
			portBOut <= mb1Data;
		end
	end

	// port A read side of queue two, one whole word per read
	assign q2Pop  = fallThrough ? (!aShown || aRd) : aRd;
	assign q2Take = q2Pop && q2Valid && !q2Clear;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aShown <= 1'b0;
		end else if (q2Clear || !fallThrough) begin
			aShown <= 1'b0;
		end else if (q2Take) begin
			aShown <= 1'b1; // first word falls through unread
		end else if (aRd) begin
			aShown <= 1'b0;
		end
	end

	// port A data and drive enable; mail reads use the low 18 bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			portAOut  <= '0;
			portAOe_n <= 1'b1;
		end else begin
			portAOe_n <= !portAOutEnable;
			if (q2Take) begin
				portAOut <= q2Data;
			end else if (portARead && portAMailSel) begin
				portAOut <= {18'h00000, mb2Data};
			end
		end
	end

	// port C pairing: first half waits, second half pushes if there is room
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cHalf <= 1'b0;
			cLow  <= '0;
		end else if (q2Clear) begin
			cHalf <= 1'b0;
		end else if (cWr && !cHalf) begin
			cLow  <= portCIn;
			cHalf <= 1'b1;
		end else if (q2Push && q2InReady) begin
			cHalf <= 1'b0; // refused second half is dropped; the first half stays held
		end
	end

	// flags: full/empty in standard, room/valid in fall-through
	assign portAFullOrRoom   = q1InReady; // writer side of queue one
	assign portCFullOrRoom   = q2InReady && !q2Clear;
	assign portBEmptyOrValid = fallThrough ? (bState != OS_EMPTY) : (q1Valid || bState == OS_SECOND);
	assign portAEmptyOrValid = fallThrough ? aShown : q2Valid;

	// almost flags, active low, registered so parallel parts match
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			portBAlmostEmpty <= 1'b0;
			portAAlmostEmpty <= 1'b0;
			portAAlmostFull  <= 1'b1;
			portCAlmostFull  <= 1'b1;
		end else begin
			portBAlmostEmpty <= ({1'b0, q1Count} > offs1.ae);
			portAAlmostEmpty <= ({1'b0, q2Count} > offs2.ae);
			portAAlmostFull  <= (7'(`TBF_DEPTH) - {1'b0, q1Count} > offs1.af);
			portCAlmostFull  <= (7'(`TBF_DEPTH) - {1'b0, q2Count} > offs2.af);
		end
	end

	// master reset with a given flag-select code
	sequence s_mrs16;
		fullResetQueueOne && flagSel == `TBF_FS_16;
	endsequence
	sequence s_mrs64;
		fullResetQueueTwo && flagSel == `TBF_FS_64;
	endsequence

	a_mrs_default16: assert property (@(posedge clk) disable iff (rst)
		s_mrs16 |=> offs1.ae == 7'h10 && offs1.af == 7'h10 && q1Count == 6'h00)
		else $error("queue one default offset wrong");
	a_mrs_default64: assert property (@(posedge clk) disable iff (rst)
		s_mrs64 |=> offs2.ae == 7'h40 && !cfg2.progMode && !portAEmptyOrValid)
		else $error("queue two master reset wrong");
	a_prs_keeps: assert property (@(posedge clk) disable iff (rst)
		flushResetQueueOne && !fullResetQueueOne && !portAWrite && !serialOffsetEn
		|=> offs1 == $past(offs1) && cfg1 == $past(cfg1))
		else $error("partial reset changed settings");
	a_std_holds: assert property (@(posedge clk) disable iff (rst)
		!fallThrough && bState == OS_EMPTY && !portBRead |=> bState == OS_EMPTY)
		else $error("standard mode showed word unread");
	a_fall_through_mode_falls: assert property (@(posedge clk) disable iff (rst)
		fallThrough && bState == OS_EMPTY && q1Valid && !q1Clear
		|=> bState == OS_FIRST && portBEmptyOrValid)
		else $error("first word did not fall through");
	a_ae_level: assert property (@(posedge clk) disable iff (rst)
		##1 portBAlmostEmpty == ({1'b0, $past(q1Count)} > $past(offs1.ae)))
		else $error("almost-empty flag wrong");
	a_af_level: assert property (@(posedge clk) disable iff (rst)
		##1 portCAlmostFull == (7'h20 - {1'b0, $past(q2Count)} > $past(offs2.af)))
		else $error("almost-full flag wrong");
endmodule

// >>> tbf_port_b_model.sv
/*
 * Port B reader model: logic on the far side of the 18-bit read port.
 * Assumes the block's clk; drives its strobes at the falling edge.
 */
`timescale 1ns/1ps
module tbf_port_b_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        en,
	input  wire logic        slow,
	input  wire logic        mailGo,
	input  wire logic        portBEmptyOrValid,
	input  wire logic [17:0] portBOut,
	output logic             portBRead,
	output logic             portBMailSel
);
	logic        readReg;
	logic        taken;
	logic [1:0]  tick;
	logic [17:0] got [0:63];
	int          n;
	// a mail read is one strobe cycle ordered by the bench
	assign portBRead    = readReg | mailGo;
	assign portBMailSel = mailGo;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) taken <= 1'b0;
		else taken <= readReg;
	end
	// strobe moves only off the sampling edge; slow mode stalls 3 of 4 cycles
	always @(negedge clk or posedge rst) begin
		if (rst) begin
			readReg <= 1'b0;
			tick    <= 2'h0;
			n       <= 0;
		end else begin
			tick    <= tick + 2'h1;
			readReg <= en & portBEmptyOrValid & (!slow | tick == 2'h0);
			if (taken) begin
				got[n] <= portBOut;
				n      <= n + 1;
			end
		end
	end
endmodule

// >>> tbf_top_tb.sv
/*
 * Self-checking bench for the tri-port two-queue FIFO.
 * Assumes one 200 MHz clock; bench inputs move at the falling edge.
 */
`timescale 1ns/1ps
module tbf_top_tb;
	logic clk, rst, fullResetQueueOne, fullResetQueueTwo, flushResetQueueOne, flushResetQueueTwo;
	logic flagSelect0, flagSelect1, bigEndianSel, serialOffsetIn, serialOffsetEn, outputModeSelect;
	logic [35:0] portAIn, portAOut;
	logic portAOe_n, portAOutEnable, portAWrite, portARead, portAMailSel, portAProgSel;
	logic portAFullOrRoom, portAEmptyOrValid, portAAlmostEmpty, portAAlmostFull, mailFlagOne, mailFlagTwo;
	logic [17:0] portBOut, portCIn;
	logic portBRead, portBMailSel, portBEmptyOrValid, portBAlmostEmpty;
	logic portCWrite, portCMailSel, portCFullOrRoom, portCAlmostFull, bEn, bSlow, bMail;
	int miscompares, nChecks, wc, k;
	// serial offset word: ae of queue one 5, af of queue one 8
	localparam logic [27:0] SER_WORD = 28'h0000805;
	tbf_top u_dut (.clk(clk), .rst(rst), .fullResetQueueOne(fullResetQueueOne),
		.fullResetQueueTwo(fullResetQueueTwo), .flushResetQueueOne(flushResetQueueOne),
		.flushResetQueueTwo(flushResetQueueTwo), .flagSelect0(flagSelect0), .flagSelect1(flagSelect1),
		.bigEndianSel(bigEndianSel), .serialOffsetIn(serialOffsetIn), .serialOffsetEn(serialOffsetEn),
		.outputModeSelect(outputModeSelect), .portAIn(portAIn), .portAOut(portAOut), .portAOe_n(portAOe_n),
		.portAOutEnable(portAOutEnable), .portAWrite(portAWrite), .portARead(portARead),
		.portAMailSel(portAMailSel), .portAProgSel(portAProgSel), .portAFullOrRoom(portAFullOrRoom),
		.portAEmptyOrValid(portAEmptyOrValid), .portAAlmostEmpty(portAAlmostEmpty),
		.portAAlmostFull(portAAlmostFull), .mailFlagOne(mailFlagOne), .mailFlagTwo(mailFlagTwo),
		.portBOut(portBOut), .portBRead(portBRead), .portBMailSel(portBMailSel),
		.portBEmptyOrValid(portBEmptyOrValid), .portBAlmostEmpty(portBAlmostEmpty), .portCIn(portCIn),
		.portCWrite(portCWrite), .portCMailSel(portCMailSel), .portCFullOrRoom(portCFullOrRoom),
		.portCAlmostFull(portCAlmostFull));
	tbf_port_b_model u_part (.clk(clk), .rst(rst), .en(bEn), .slow(bSlow), .mailGo(bMail),
		.portBEmptyOrValid(portBEmptyOrValid), .portBOut(portBOut), .portBRead(portBRead),
		.portBMailSel(portBMailSel));
	// free-running block clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic printVerdict;
		if (miscompares == 0 && nChecks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chkData(input logic [35:0] g, input logic [35:0] e);
		nChecks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chkFlag(input logic g, input logic e);
		chkData({35'h0, g}, {35'h0, e});
	endtask
	task automatic cyc(input int c);
		repeat (c) @(negedge clk);
	endtask
	// queue-level master reset latching flag select and byte order
	task automatic mres(input logic q2, input logic [1:0] code, input logic be);
		{flagSelect1, flagSelect0} = code;
		bigEndianSel = be;
		fullResetQueueOne = !q2;
		fullResetQueueTwo = q2;
		cyc(1);
		fullResetQueueOne = 1'b0;
		fullResetQueueTwo = 1'b0;
		cyc(1);
	endtask
	// back-to-back queue one writes; halves differ so order errors show
	task automatic fillA(input int upto);
		while (wc < upto) begin
			portAWrite = 1'b1;
			portAIn = {18'(wc + 100), 18'(wc)};
			wc++;
			cyc(1);
		end
		portAWrite = 1'b0;
		cyc(2);
	endtask
	task automatic wrC(input logic [17:0] h);
		portCWrite = 1'b1;
		portCIn = h;
		cyc(1);
	endtask
	task automatic rdA;
		portARead = 1'b1;
		cyc(1);
		portARead = 1'b0;
		cyc(1);
	endtask
	task automatic s_std;
		mres(1'b0, 2'h1, 1'b0);
		chkFlag(portBAlmostEmpty, 1'b0);
		wc = 0;
		fillA(8);
		chkFlag(portBAlmostEmpty, 1'b0);
		fillA(9);
		chkFlag(portBAlmostEmpty, 1'b1);
		fillA(23);
		chkFlag(portAAlmostFull, 1'b1);
		fillA(24);
		chkFlag(portAAlmostFull, 1'b0);
		fillA(33);
		chkFlag(portAFullOrRoom, 1'b0);
		chkData({18'h0, portBOut}, 36'h0);
		bEn = 1'b1;
		bSlow = 1'b1;
		for (k = 0; k < 600 && u_part.n < 64; k++) cyc(1);
		cyc(20);
		chkData(36'(u_part.n), 36'd64);
		chkFlag(portBEmptyOrValid, 1'b0);
		for (k = 0; k < 32; k++) begin
			chkData({18'h0, u_part.got[2*k]}, 36'(k));
			chkData({18'h0, u_part.got[2*k+1]}, 36'(k + 100));
		end
		bEn = 1'b0;
	endtask
	task automatic s_mail;
		{portAWrite, portAMailSel, portAIn} = {2'h3, 36'h00002A5C3};
		cyc(1);
		{portAWrite, portAMailSel} = 2'h0;
		cyc(1);
		chkFlag(mailFlagOne, 1'b1);
		bMail = 1'b1;
		cyc(1);
		bMail = 1'b0;
		cyc(1);
		chkData({18'h0, portBOut}, 36'h00002A5C3);
		chkFlag(mailFlagOne, 1'b0);
		{portCWrite, portCMailSel, portCIn} = {2'h3, 18'h15A3C};
		cyc(1);
		{portCWrite, portCMailSel} = 2'h0;
		cyc(1);
		chkFlag(mailFlagTwo, 1'b1);
		portAMailSel = 1'b1;
		rdA;
		portAMailSel = 1'b0;
		chkData(portAOut, 36'h000015A3C);
		chkFlag(mailFlagTwo, 1'b0);
	endtask
	task automatic s_fall_through_mode;
		outputModeSelect = 1'b1;
		portAOutEnable = 1'b1;
		mres(1'b1, 2'h2, 1'b1);
		chkFlag(portAOe_n, 1'b0);
		wc = 5;
		fillA(7);
		chkFlag(portBEmptyOrValid, 1'b1);
		chkData({18'h0, portBOut}, 36'h000000005);
		wrC(18'h12345);
		wrC(18'h2ABCD);
		wrC(18'h0F0F0);
		wrC(18'h30303);
		portCWrite = 1'b0;
		cyc(3);
		chkFlag(portAEmptyOrValid, 1'b1);
		chkData(portAOut, {18'h12345, 18'h2ABCD});
		rdA;
		chkData(portAOut, {18'h0F0F0, 18'h30303});
		rdA;
		chkFlag(portAEmptyOrValid, 1'b0);
		portAOutEnable = 1'b0;
		outputModeSelect = 1'b0;
	endtask
	task automatic s_flush;
		mres(1'b0, 2'h0, 1'b0);
		{portAWrite, portAProgSel, portAIn} = {2'h3, 36'h008080803};
		cyc(1);
		portAProgSel = 1'b0;
		wc = 0;
		fillA(4);
		chkFlag(portBAlmostEmpty, 1'b1);
		wrC(18'h00001);
		wrC(18'h00002);
		portCWrite = 1'b0;
		flushResetQueueOne = 1'b1;
		cyc(1);
		flushResetQueueOne = 1'b0;
		cyc(2);
		chkFlag(portBEmptyOrValid, 1'b0);
		chkFlag(portBAlmostEmpty, 1'b0);
		chkFlag(portAEmptyOrValid, 1'b1);
		wc = 0;
		fillA(4);
		chkFlag(portBAlmostEmpty, 1'b1);
		// serial load, first bit shifted is the top bit of the word
		serialOffsetEn = 1'b1;
		for (k = 27; k >= 0; k--) begin
			serialOffsetIn = SER_WORD[k];
			cyc(1);
		end
		serialOffsetEn = 1'b0;
		serialOffsetIn = 1'b0;
		cyc(2);
		chkFlag(portBAlmostEmpty, 1'b0);
		// queue two holds one word; 31 more fill it to the brim
		for (k = 0; k < 62; k++) wrC(18'(k));
		portCWrite = 1'b0;
		cyc(2);
		chkFlag(portCFullOrRoom, 1'b0);
		chkFlag(portCAlmostFull, 1'b0);
		chkFlag(portAAlmostEmpty, 1'b1);
	endtask
	// cut a hang short well past the few hundred cycles the run needs
	initial begin
		#(20000 * 5);
		miscompares++;
		printVerdict;
	end
	initial begin
		{fullResetQueueOne, fullResetQueueTwo, flushResetQueueOne, flushResetQueueTwo} = 4'h0;
		{flagSelect0, flagSelect1, bigEndianSel, serialOffsetIn, serialOffsetEn} = 5'h00;
		{outputModeSelect, portAOutEnable, portAWrite, portARead, portAMailSel, portAProgSel} = 6'h00;
		{portAIn, portCIn, portCWrite, portCMailSel, bEn, bSlow, bMail} = '0;
		miscompares = 0;
		nChecks = 0;
		rst = 1'b1;
		cyc(8);
		rst = 1'b0;
		s_std;
		s_mail;
		s_fall_through_mode;
		s_flush;
		printVerdict;
	end
endmodule
